// ==== fcd_bus_if.sv ====
// parallel flash bus between host end and device end
// assumes both ends run on the same aclk
`timescale 1ns/100ps
`default_nettype none
interface fcd_bus_if;
	logic we;
	logic re;
	logic [fcd_pkg::AW-1:0] addr;
	logic [fcd_pkg::DW-1:0] dq_h;
	logic dq_h_oen;
	logic [fcd_pkg::DW-1:0] dq_d;
	logic dq_d_oen;
	logic rst_n;
	wire [fcd_pkg::DW-1:0] dq;

	// resolved data lines, idle bus reads zero
	assign dq = !dq_d_oen ? dq_d : (!dq_h_oen ? dq_h : '0);

	modport dev (input we, re, addr, dq, rst_n, output dq_d, dq_d_oen);
	modport host (input dq, dq_d_oen, output we, re, addr, dq_h, dq_h_oen, rst_n);
endinterface : fcd_bus_if
`default_nettype wire

// ==== fcd_checker.sv ====
// concurrent checks on the flash bus between host end and device end
// assumes one aclk and a synchronous active-low aresetn
`timescale 1ns/100ps
`default_nettype none
module fcd_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// flash bus
	input wire logic we,
	input wire logic re,
	input wire logic [fcd_pkg::AW-1:0] addr,
	input wire logic [fcd_pkg::DW-1:0] dq_h,
	input wire logic dq_h_oen,
	input wire logic [fcd_pkg::DW-1:0] dq_d,
	input wire logic dq_d_oen,
	input wire logic rst_n,
	input wire logic [fcd_pkg::DW-1:0] dq
);
	import fcd_pkg::*;
	logic stat_sel_r;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------
	// helper
	// ----------------------------------------
	// any other write drops it, so a missed case only weakens the check
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rst_n)
			stat_sel_r <= 1'b0;
		else if (we)
			stat_sel_r <= (dq == {8'h00, CMD_READ_STATUS});
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	read_answer_a : assert property (re |=> !dq_d_oen && dq == dq_d)
		else $error("read not answered next cycle");
	oen_single_a : assert property (!dq_d_oen |=> dq_d_oen)
		else $error("device drove bus two cycles");
	oen_cause_a : assert property (!dq_d_oen |-> $past(re))
		else $error("device drove bus without a read");
	write_gap_a : assert property (we |=> !we && !re)
		else $error("bus cycles too close");
	host_drive_a : assert property (we |-> !dq_h_oen && dq == dq_h)
		else $error("write data not on bus");
	no_clash_a : assert property (!dq_h_oen |-> we && dq_d_oen)
		else $error("host drives outside write or against device");
	rst_hold_a : assert property ($fell(rst_n) |-> !rst_n [*4] ##1 rst_n)
		else $error("device reset pulse length wrong");
	rst_quiet_a : assert property (!rst_n |=> dq_d_oen && !we)
		else $error("bus active during device reset");
	status_byte_a : assert property (re && stat_sel_r |=> dq[15:8] == 8'h00)
		else $error("status read upper byte not zero");
	addr_hold_a : assert property ((we || re) |-> $stable(addr))
		else $error("address moved at a bus strobe");

	// main scenarios seen
	cover property (re ##1 !dq_d_oen);
	cover property ($fell(rst_n));
	cover property (we && dq == {8'h00, CMD_SUSPEND});
endmodule : fcd_checker
`default_nettype wire

// ==== fcd_device.sv ====
// device end: command decoder, read modes, status and program buffer
// assumes the host keeps one bus cycle per strobe, all on aclk
`timescale 1ns/100ps
`default_nettype none
module fcd_device (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// flash bus
	fcd_bus_if.dev bus,
	// read sources
	output logic [fcd_pkg::AW-1:0] arr_raddr,
	input wire logic [fcd_pkg::DW-1:0] arr_rdata,
	input wire logic [fcd_pkg::DW-1:0] id_rdata,
	input wire logic [fcd_pkg::DW-1:0] qry_rdata,
	// finished work
	output logic prog_req,
	output logic otp_req,
	output logic erase_req,
	output logic [fcd_pkg::AW-1:0] prog_addr,
	output logic [fcd_pkg::DW-1:0] prog_data,
	output logic lock_req,
	output logic [1:0] lock_kind,
	output logic [fcd_pkg::AW-1:0] lock_addr,
	output logic [fcd_pkg::DW-1:0] rcfg
);
	import fcd_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic rst_n;
	logic [7:0] cmd;
	fcd_dec_t st_r, st_nxt;
	fcd_rmode_t mode_r, mode_nxt;
	fcd_job_t job_r, go_job;
	logic go, seq_err, clr_err, do_susp, do_res, lock_go, cfg_go, bcnt_go, bdat_go, fset_go;
	logic [1:0] kind_nxt;
	logic eng_busy, eng_susp, fin, running, more, eng_start;
	logic [1:0] err_r;
	logic [4:0] bcnt_r, widx_r, ridx_r;
	logic [AW-1:0] bbase_r, jaddr_r;
	logic [DW-1:0] jdata_r, rd_val;
	logic [DW-1:0] buf_r [BUF_WORDS];
	logic [AW-BLK_LSB-1:0] fblk_r;
	logic [7:0] status;

	assign rst_n = aresetn & bus.rst_n;
	assign cmd = bus.dq[7:0];
	assign arr_raddr = bus.addr;
	assign running = eng_busy & ~eng_susp;
	assign more = (job_r == JB_BUF) && (ridx_r != bcnt_r);
	// buffer words chain without bus cycles
	assign eng_start = go | (fin & more);

	// suspend flags follow the job kind
	assign status = {~eng_busy | eng_susp, eng_susp & (job_r == JB_ERASE), err_r, 1'b0,
		eng_susp & (job_r != JB_ERASE), 2'b00};

	fcd_write_sm u_eng (
		.aclk(aclk),
		.rst_n(rst_n),
		.start(eng_start),
		.erase(go && (go_job == JB_ERASE)),
		.suspend(do_susp),
		.resume(do_res),
		.busy(eng_busy),
		.susp(eng_susp),
		.fin(fin)
	);

	// ----------------------------------------
	// command decoder
	// ----------------------------------------
	// codes decoded against the pending setup
	always_comb
	begin
		st_nxt = st_r;
		mode_nxt = mode_r;
		go = 1'b0;
		go_job = JB_WORD;
		seq_err = 1'b0;
		clr_err = 1'b0;
		do_susp = 1'b0;
		do_res = 1'b0;
		lock_go = 1'b0;
		kind_nxt = LK_LOCK;
		cfg_go = 1'b0;
		bcnt_go = 1'b0;
		bdat_go = 1'b0;
		fset_go = 1'b0;
		if (bus.we)
		begin
			if (st_r == DS_FRUN)
			begin
				// stream ends at a write outside the block
				if (bus.addr[AW-1:BLK_LSB] != fblk_r)
				begin
					st_nxt = DS_IDLE;
					mode_nxt = RM_STATUS;
				end
				else if (!eng_busy)
				begin
					go = 1'b1;
					go_job = JB_FBP;
				end
			end
			else if (running)
			begin
				if (cmd == CMD_READ_STATUS)
					mode_nxt = RM_STATUS;
				if (cmd == CMD_SUSPEND)
				begin
					do_susp = 1'b1;
					mode_nxt = RM_STATUS;
				end
			end
			else
			begin
				case (st_r)
					DS_IDLE:
					begin
						case (cmd)
							CMD_READ_ARRAY: mode_nxt = RM_ARRAY;
							CMD_READ_STATUS: mode_nxt = RM_STATUS;
							CMD_READ_ID: mode_nxt = RM_ID;
							CMD_QUERY: mode_nxt = RM_QUERY;
							CMD_CLEAR_STAT: clr_err = 1'b1;
							CMD_CONFIRM: do_res = eng_susp;
							CMD_LOCK_SETUP: st_nxt = DS_LOCK;
							CMD_OTP: st_nxt = DS_OTP;
							default:
							begin
							end
						endcase
						// program/erase setups go to status read
						if (!eng_susp)
						begin
							if (cmd == CMD_PROG || cmd == CMD_PROG_ALT)
								st_nxt = DS_PROG;
							else if (cmd == CMD_BUF_PROG)
								st_nxt = DS_BCNT;
							else if (cmd == CMD_FBP)
								st_nxt = DS_FSET;
							else if (cmd == CMD_ERASE)
								st_nxt = DS_ERASE;
							if (st_nxt != DS_IDLE && st_nxt != DS_LOCK && st_nxt != DS_OTP)
								mode_nxt = RM_STATUS;
						end
					end
					DS_PROG:
					begin
						go = 1'b1;
						st_nxt = DS_IDLE;
					end
					DS_BCNT:
					begin
						bcnt_go = 1'b1;
						st_nxt = DS_BDATA;
					end
					DS_BDATA:
					begin
						bdat_go = 1'b1;
						if (widx_r == bcnt_r)
							st_nxt = DS_BCONF;
					end
					DS_BCONF:
					begin
						go = (cmd == CMD_CONFIRM);
						go_job = JB_BUF;
						seq_err = ~go;
						st_nxt = DS_IDLE;
					end
					DS_FSET:
					begin
						fset_go = (cmd == CMD_CONFIRM);
						seq_err = ~fset_go;
						st_nxt = fset_go ? DS_FRUN : DS_IDLE;
					end
					DS_ERASE:
					begin
						go = (cmd == CMD_CONFIRM);
						go_job = JB_ERASE;
						seq_err = ~go;
						st_nxt = DS_IDLE;
					end
					DS_LOCK:
					begin
						lock_go = (cmd == CMD_LOCK) || (cmd == CMD_CONFIRM) || (cmd == CMD_LOCKDOWN);
						kind_nxt = (cmd == CMD_LOCK) ? LK_LOCK : ((cmd == CMD_CONFIRM) ? LK_UNLOCK : LK_DOWN);
						cfg_go = (cmd == CMD_CFG);
						seq_err = ~lock_go & ~cfg_go;
						st_nxt = DS_IDLE;
					end
					DS_OTP:
					begin
						go = 1'b1;
						go_job = JB_OTP;
						st_nxt = DS_IDLE;
					end
					default: st_nxt = DS_IDLE;
				endcase
				if (seq_err)
					mode_nxt = RM_STATUS;
			end
		end
	end

	// decoder and read mode state
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			st_r <= DS_IDLE;
			mode_r <= RM_ARRAY;
			fblk_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			mode_r <= mode_nxt;
			if (fset_go)
				fblk_r <= bus.addr[AW-1:BLK_LSB];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			err_r <= STAT_RESET[5:4];
		else
			err_r <= (err_r & {2{~clr_err}}) | {2{seq_err}};
	end

	// ----------------------------------------
	// program buffer and job
	// ----------------------------------------
	// buffer load, base taken from first word
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			bcnt_r <= '0;
			widx_r <= '0;
			bbase_r <= '0;
		end
		else if (bcnt_go)
		begin
			bcnt_r <= bus.dq[4:0];
			widx_r <= '0;
		end
		else if (bdat_go)
		begin
			buf_r[widx_r] <= bus.dq;
			widx_r <= widx_r + 5'h01;
			if (widx_r == '0)
				bbase_r <= bus.addr;
		end
	end

	// job latch, buffer read index advances per word
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			job_r <= JB_WORD;
			jaddr_r <= '0;
			jdata_r <= '0;
			ridx_r <= '0;
		end
		else if (go)
		begin
			job_r <= go_job;
			jaddr_r <= (go_job == JB_BUF) ? bbase_r : bus.addr;
			jdata_r <= bus.dq;
			ridx_r <= '0;
		end
		else if (fin && more)
			ridx_r <= ridx_r + 5'h01;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// completion pulses, aborted work emits nothing
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			prog_req <= 1'b0;
			otp_req <= 1'b0;
			erase_req <= 1'b0;
			prog_addr <= '0;
			prog_data <= '0;
			lock_req <= 1'b0;
			lock_kind <= LK_LOCK;
			lock_addr <= '0;
			rcfg <= CFG_RESET;
		end
		else
		begin
			prog_req <= fin & (job_r != JB_ERASE) & (job_r != JB_OTP);
			otp_req <= fin & (job_r == JB_OTP);
			erase_req <= fin & (job_r == JB_ERASE);
			if (fin)
			begin
				prog_addr <= (job_r == JB_BUF) ? jaddr_r + AW'(ridx_r) : jaddr_r;
				prog_data <= (job_r == JB_BUF) ? buf_r[ridx_r] : jdata_r;
			end
			lock_req <= lock_go;
			if (lock_go)
			begin
				lock_kind <= kind_nxt;
				lock_addr <= bus.addr;
			end
			// value comes from the address lines
			if (cfg_go)
				rcfg <= bus.addr[DW-1:0];
		end
	end

	// read source by mode
	always_comb
	begin
		case (mode_r)
			RM_STATUS: rd_val = {8'h00, status};
			RM_ID:
			begin
				case (bus.addr[7:0])
					ID_OFS_MAKER: rd_val = MAKER_CODE;
					ID_OFS_PART: rd_val = PART_CODE;
					ID_OFS_CFG: rd_val = rcfg;
					default: rd_val = id_rdata;
				endcase
			end
			RM_QUERY: rd_val = qry_rdata;
			default: rd_val = arr_rdata;
		endcase
	end

	// read answer one cycle after the strobe
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			bus.dq_d <= '0;
			bus.dq_d_oen <= 1'b1;
		end
		else
		begin
			bus.dq_d <= rd_val;
			bus.dq_d_oen <= ~bus.re;
		end
	end
endmodule : fcd_device
`default_nettype wire

// ==== fcd_host.sv ====
// host end: AXI4-Lite registers turned into flash bus cycles
// assumes the device answers a read with dq_d_oen low
`timescale 1ns/100ps
`default_nettype none
module fcd_host (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// flash bus
	fcd_bus_if.host bus
);
	import fcd_pkg::*;

	fcd_hst_t st_r;
	logic aw_ok_r, w_ok_r, wr_go, ctl_go;
	logic [7:0] awa_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic [AW-1:0] haddr_r;
	logic [DW-1:0] hdata_r, rdat_r;
	logic [2:0] rcnt_r;

	assign s_awready = ~aw_ok_r & ~s_bvalid;
	assign s_wready = ~w_ok_r & ~s_bvalid;
	assign s_arready = ~s_rvalid;
	assign wr_go = aw_ok_r & w_ok_r & ~s_bvalid;
	// commands while busy are dropped
	assign ctl_go = wr_go && (awa_r == HREG_CTRL) && (st_r == HS_IDLE);
	assign bus.addr = haddr_r;
	assign bus.dq_h = hdata_r;

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	// address and data may come in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awa_r <= '0;
			wd_r <= '0;
			ws_r <= '0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'b00;
			haddr_r <= '0;
			hdata_r <= '0;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_ok_r <= 1'b1;
				awa_r <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_ok_r <= 1'b1;
				wd_r <= s_wdata;
				ws_r <= s_wstrb;
			end
			if (wr_go)
			begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (awa_r[1:0] == 2'b00 && awa_r <= HREG_STAT) ? 2'b00 : 2'b10;
				for (int i = 0; i < 3; i++)
				begin
					if (awa_r == HREG_ADDR && ws_r[i])
						haddr_r[i*8 +: 8] <= wd_r[i*8 +: 8];
				end
				// data register has two byte lanes only
				for (int j = 0; j < 2; j++)
				begin
					if (awa_r == HREG_DATA && ws_r[j])
						hdata_r[j*8 +: 8] <= wd_r[j*8 +: 8];
				end
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	// register reads, one cycle after arvalid
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= 2'b00;
		end
		else if (s_arvalid && s_arready)
		begin
			s_rvalid <= 1'b1;
			s_rresp <= 2'b00;
			case (s_araddr)
				HREG_ADDR: s_rdata <= {8'h00, haddr_r};
				HREG_DATA: s_rdata <= {16'h0000, hdata_r};
				HREG_CTRL: s_rdata <= '0;
				HREG_STAT: s_rdata <= {rdat_r, 15'h0000, st_r != HS_IDLE};
				default:
				begin
					s_rdata <= '0;
					s_rresp <= 2'b10;
				end
			endcase
		end
		else if (s_rvalid && s_rready)
			s_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// bus cycle sequencer
	// ----------------------------------------
	// one address register serves every cycle
	// reset pulse held a fixed count
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= HS_IDLE;
			bus.we <= 1'b0;
			bus.re <= 1'b0;
			bus.dq_h_oen <= 1'b1;
			bus.rst_n <= 1'b1;
			rdat_r <= '0;
			rcnt_r <= '0;
		end
		else
		begin
			case (st_r)
				HS_IDLE:
				begin
					if (ctl_go && ws_r[0])
					begin
						if (wd_r[CTRL_RST])
						begin
							st_r <= HS_RST;
							bus.rst_n <= 1'b0;
							rcnt_r <= 3'(RST_HOLD_CYC - 1);
						end
						else if (wd_r[CTRL_WR])
						begin
							st_r <= HS_WR;
							bus.we <= 1'b1;
							bus.dq_h_oen <= 1'b0;
						end
						else if (wd_r[CTRL_RD])
						begin
							st_r <= HS_RD;
							bus.re <= 1'b1;
						end
					end
				end
				HS_WR:
				begin
					st_r <= HS_IDLE;
					bus.we <= 1'b0;
					bus.dq_h_oen <= 1'b1;
				end
				// die base plus offset is in the address register
				HS_RD:
				begin
					bus.re <= 1'b0;
					if (!bus.dq_d_oen)
					begin
						rdat_r <= bus.dq;
						st_r <= HS_IDLE;
					end
				end
				HS_RST:
				begin
					if (rcnt_r == '0)
					begin
						bus.rst_n <= 1'b1;
						st_r <= HS_IDLE;
					end
					else
						rcnt_r <= rcnt_r - 3'h1;
				end
				default: st_r <= HS_IDLE;
			endcase
		end
	end
endmodule : fcd_host
`default_nettype wire

// ==== fcd_pkg.sv ====
// constants and types shared by both ends of the flash command bus
// assumes a single 100 MHz clock on both ends
package fcd_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int AW = 24;
	localparam int DW = 16;
	localparam int BUF_WORDS = 32;
	localparam int BLK_LSB = 16;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_CLEAR_STAT = 8'h50;
	localparam logic [7:0] CMD_PROG = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT = 8'h10;
	localparam logic [7:0] CMD_BUF_PROG = 8'he8;
	localparam logic [7:0] CMD_FBP = 8'h80;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK = 8'h01;
	localparam logic [7:0] CMD_LOCKDOWN = 8'h2f;
	localparam logic [7:0] CMD_CFG = 8'h03;
	localparam logic [7:0] CMD_OTP = 8'hc0;

	// ----------------------------------------
	// status and identifier layout
	// ----------------------------------------
	localparam logic [7:0] STAT_RESET = 8'h80;
	localparam logic [7:0] ID_OFS_MAKER = 8'h00;
	localparam logic [7:0] ID_OFS_PART = 8'h01;
	localparam logic [7:0] ID_OFS_CFG = 8'h05;
	// arbitrary neutral identity values
	localparam logic [15:0] MAKER_CODE = 16'h00a5;
	localparam logic [15:0] PART_CODE = 16'h005a;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [1:0] LK_LOCK = 2'h1;
	localparam logic [1:0] LK_UNLOCK = 2'h2;
	localparam logic [1:0] LK_DOWN = 2'h3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS = 10;
	localparam int PROG_NS = 2000;
	localparam int ERASE_NS = 30000;
	localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 12;
	localparam int RST_HOLD_CYC = 4;

	// ----------------------------------------
	// host register map
	// ----------------------------------------
	localparam logic [7:0] HREG_ADDR = 8'h00;
	localparam logic [7:0] HREG_DATA = 8'h04;
	localparam logic [7:0] HREG_CTRL = 8'h08;
	localparam logic [7:0] HREG_STAT = 8'h0c;
	localparam int CTRL_WR = 0;
	localparam int CTRL_RD = 1;
	localparam int CTRL_RST = 2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {RM_ARRAY = 4'b0001, RM_STATUS = 4'b0010, RM_ID = 4'b0100,
		RM_QUERY = 4'b1000} fcd_rmode_t;
	typedef enum logic [4:0] {JB_WORD = 5'b00001, JB_BUF = 5'b00010, JB_FBP = 5'b00100,
		JB_ERASE = 5'b01000, JB_OTP = 5'b10000} fcd_job_t;
	typedef enum logic [9:0] {DS_IDLE = 10'h001, DS_PROG = 10'h002, DS_BCNT = 10'h004,
		DS_BDATA = 10'h008, DS_BCONF = 10'h010, DS_FSET = 10'h020, DS_FRUN = 10'h040,
		DS_ERASE = 10'h080, DS_LOCK = 10'h100, DS_OTP = 10'h200} fcd_dec_t;
	typedef enum logic [3:0] {HS_IDLE = 4'b0001, HS_WR = 4'b0010, HS_RD = 4'b0100,
		HS_RST = 4'b1000} fcd_hst_t;

endpackage : fcd_pkg

// ==== fcd_tb_top.sv ====
// self-checking bench: host end and device end joined over the flash bus
// assumes a 100 MHz aclk and a bench-driven axi4-lite master
`timescale 1ns/100ps
`default_nettype none
module fcd_tb_top;
	import fcd_pkg::*;
	logic aclk, aresetn;
	logic [7:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd;
	logic [3:0] s_wstrb;
	logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, rsp;
	logic [AW-1:0] arr_raddr, prog_addr, lock_addr;
	logic [DW-1:0] arr_rdata, id_rdata, qry_rdata, prog_data, rcfg, d;
	logic prog_req, otp_req, erase_req, lock_req;
	logic [1:0] lock_kind;
	logic [43:0] evq[$];
	int err_count, cmp_count;
	fcd_bus_if bus ();

	fcd_host fcd_host_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.bus(bus));
	fcd_device fcd_device_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus), .arr_raddr(arr_raddr),
		.arr_rdata(arr_rdata), .id_rdata(id_rdata), .qry_rdata(qry_rdata), .prog_req(prog_req),
		.otp_req(otp_req), .erase_req(erase_req), .prog_addr(prog_addr), .prog_data(prog_data),
		.lock_req(lock_req), .lock_kind(lock_kind), .lock_addr(lock_addr), .rcfg(rcfg));
	fcd_checker fcd_checker_inst (.aclk(aclk), .aresetn(aresetn), .we(bus.we), .re(bus.re), .addr(bus.addr),
		.dq_h(bus.dq_h), .dq_h_oen(bus.dq_h_oen), .dq_d(bus.dq_d), .dq_d_oen(bus.dq_d_oen), .rst_n(bus.rst_n),
		.dq(bus.dq));

	// free-running clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// finished-work pulses, sampled mid-cycle to stay clear of the edge
	always @(negedge aclk)
	begin
		if (prog_req === 1'b1) evq.push_back({4'h1, prog_addr, prog_data});
		if (otp_req === 1'b1) evq.push_back({4'h2, prog_addr, prog_data});
		if (erase_req === 1'b1) evq.push_back({4'h3, prog_addr, 16'h0000});
		if (lock_req === 1'b1) evq.push_back({4'h4, lock_addr, 14'h0000, lock_kind});
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [43:0] g, input logic [43:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		chk({28'h0, g}, {28'h0, e});
	endtask : chk16

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_ok, w_ok;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			aw_ok = s_awvalid && s_awready;
			w_ok = s_wvalid && s_wready;
			@(posedge aclk);
			if (aw_ok) s_awvalid <= 1'b0;
			if (w_ok) s_wvalid <= 1'b0;
		end
		while ((s_awvalid && !aw_ok) || (s_wvalid && !w_ok));
		do @(negedge aclk); while (s_bvalid !== 1'b1);
		rsp = s_bresp;
		@(posedge aclk);
		s_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(negedge aclk); while (s_arready !== 1'b1);
		@(posedge aclk);
		s_arvalid <= 1'b0;
		do @(negedge aclk); while (s_rvalid !== 1'b1);
		rd = s_rdata;
		rsp = s_rresp;
		@(posedge aclk);
		s_rready <= 1'b0;
	endtask : axi_rd

	// flash bus cycles through the host registers
	task automatic idle();
		do axi_rd(HREG_STAT); while (rd[0] !== 1'b0);
	endtask : idle

	task automatic fw(input logic [23:0] a, input logic [15:0] v);
		axi_wr(HREG_ADDR, {8'h00, a});
		axi_wr(HREG_DATA, {16'h0000, v});
		axi_wr(HREG_CTRL, 32'h1);
		idle();
	endtask : fw

	task automatic fc(input logic [23:0] a, input logic [7:0] c);
		fw(a, {8'h00, c});
	endtask : fc

	task automatic fr(input logic [23:0] a);
		axi_wr(HREG_ADDR, {8'h00, a});
		axi_wr(HREG_CTRL, 32'h2);
		idle();
		d = rd[31:16];
	endtask : fr

	task automatic wait_ev(input logic [43:0] e, input int n);
		for (int i = 0; i < n && evq.size() == 0; i++) @(negedge aclk);
		if (evq.size() == 0) chk(44'h0, e);
		else chk(evq.pop_front(), e);
	endtask : wait_ev

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_modes();
		fc(24'h0, CMD_READ_ARRAY);
		fr(24'h000123);
		chk16(d, 16'hbeef);
		chk({20'h0, arr_raddr}, 44'h000123);
		fc(24'h0, CMD_READ_STATUS);
		fr(24'h0);
		chk16(d, 16'h0080);
		fc(24'h0, CMD_READ_ID);
		fr({16'h0, ID_OFS_MAKER});
		chk16(d, MAKER_CODE);
		fr({16'h0, ID_OFS_PART});
		chk16(d, PART_CODE);
		fr(24'h000002);
		chk16(d, 16'h1111);
		fc(24'h0, CMD_QUERY);
		fr(24'h000010);
		chk16(d, 16'h2222);
		axi_wr(8'h10, 32'h0);
		chk16({14'h0, rsp}, 16'h0002);
		axi_rd(8'h14);
		chk16({14'h0, rsp}, 16'h0002);
		$display("t_modes done");
	endtask : t_modes

	task automatic t_word();
		for (int i = 0; i < 2; i++)
		begin
			fc(24'h000100, i ? CMD_PROG_ALT : CMD_PROG);
			fw(24'h000100, {15'h52e0, i[0]});
			fc(24'h0, CMD_READ_ARRAY);
			fr(24'h000100);
			chk16(d, 16'h0000);
			wait_ev({4'h1, 24'h000100, 15'h52e0, i[0]}, 400);
			fr(24'h000100);
			chk16(d, 16'h0080);
		end
		$display("t_word done");
	endtask : t_word

	task automatic t_erase();
		fc(24'h030000, CMD_ERASE);
		fc(24'h030000, CMD_CONFIRM);
		fc(24'h0, CMD_SUSPEND);
		fr(24'h0);
		chk16(d, 16'h00c0);
		repeat (3100) @(negedge aclk);
		chk16(16'(evq.size()), 16'h0);
		fc(24'h0, CMD_CONFIRM);
		wait_ev({4'h3, 24'h030000, 16'h0}, 3200);
		fc(24'h030000, CMD_ERASE);
		fc(24'h030000, CMD_READ_ARRAY);
		fr(24'h0);
		chk16(d, 16'h00b0);
		fc(24'h0, CMD_CLEAR_STAT);
		fc(24'h0, CMD_READ_STATUS);
		fr(24'h0);
		chk16(d, 16'h0080);
		$display("t_erase done");
	endtask : t_erase

	task automatic t_lock();
		logic [7:0] cd[3] = '{CMD_LOCK, CMD_CONFIRM, CMD_LOCKDOWN};
		logic [1:0] kd[3] = '{LK_LOCK, LK_UNLOCK, LK_DOWN};
		for (int i = 0; i < 3; i++)
		begin
			fc(24'h050000, CMD_LOCK_SETUP);
			fc(24'h050000, cd[i]);
			wait_ev({4'h4, 24'h050000, 14'h0, kd[i]}, 50);
		end
		fc(24'h001a2b, CMD_LOCK_SETUP);
		fc(24'h001a2b, CMD_CFG);
		chk16(rcfg, 16'h1a2b);
		fc(24'h0, CMD_READ_ID);
		fr({16'h0, ID_OFS_CFG});
		chk16(d, 16'h1a2b);
		$display("t_lock done");
	endtask : t_lock

	task automatic t_prog();
		fc(24'h000200, CMD_BUF_PROG);
		fw(24'h000200, 16'h0001);
		fw(24'h000200, 16'h1111);
		fw(24'h000201, 16'h2222);
		fc(24'h000200, CMD_CONFIRM);
		wait_ev({4'h1, 24'h000200, 16'h1111}, 400);
		wait_ev({4'h1, 24'h000201, 16'h2222}, 400);
		fc(24'h040000, CMD_FBP);
		fc(24'h040000, CMD_CONFIRM);
		fw(24'h040010, 16'h4444);
		fc(24'h000000, CMD_READ_STATUS);
		wait_ev({4'h1, 24'h040010, 16'h4444}, 400);
		fc(24'h000080, CMD_OTP);
		fw(24'h000080, 16'h0f0f);
		wait_ev({4'h2, 24'h000080, 16'h0f0f}, 400);
		fc(24'h000300, CMD_PROG);
		fw(24'h000300, 16'h1357);
		axi_wr(HREG_CTRL, 32'h4);
		idle();
		repeat (300) @(negedge aclk);
		chk16(16'(evq.size()), 16'h0);
		fr(24'h000300);
		chk16(d, 16'hbeef);
		$display("t_prog done");
	endtask : t_prog

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	// main sequence
	initial
	begin
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{s_awaddr, s_araddr, s_wdata} = '0;
		s_wstrb = 4'hf;
		arr_rdata = 16'hbeef;
		id_rdata = 16'h1111;
		qry_rdata = 16'h2222;
		err_count = 0;
		cmp_count = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_modes();
		t_word();
		t_erase();
		t_lock();
		t_prog();
		close_out();
	end

	// watchdog, well above the longest expected run
	initial
	begin
		repeat (60000) @(posedge aclk);
		err_count++;
		close_out();
	end
endmodule : fcd_tb_top
`default_nettype wire

// ==== fcd_wsm.sv ====
// internally timed program/erase sequencer of the device end
// assumes reset already combines the bus reset pin
`timescale 1ns/100ps
`default_nettype none
module fcd_write_sm (
	// clock and reset
	input wire logic aclk,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic erase,
	input wire logic suspend,
	input wire logic resume,
	// state
	output logic busy,
	output logic susp,
	output logic fin
);
	import fcd_pkg::*;

	logic [TMR_W-1:0] cnt_r;

	// last cycle of a step, start may chain the next one
	assign fin = busy & ~susp & ~suspend & (cnt_r == '0);

	// timer runs without bus cycles, pauses while suspended
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			susp <= 1'b0;
			cnt_r <= '0;
		end
		else if (start)
		begin
			busy <= 1'b1;
			susp <= 1'b0;
			cnt_r <= erase ? TMR_W'(ERASE_CYC - 1) : TMR_W'(PROG_CYC - 1);
		end
		else if (busy)
		begin
			if (suspend)
				susp <= 1'b1;
			else if (resume)
				susp <= 1'b0;
			else if (fin)
				busy <= 1'b0;
			else if (!susp)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule : fcd_write_sm
`default_nettype wire
